// File: hw/emon_pkg.sv
// constants shared by the energy and runtime monitor
//
// Contract
// [R01] Energy monitor adds output power and refreshes its displayed total once per hour.
// [R02] Four-digit panel: 0.01kWh up to 99.99, then 0.1kWh, then 1kWh past 999.9.
// [R03] Five-digit unit: 0.01kWh up to 999.99, then 0.1kWh; code shows 1kWh past 9999.9.
// [R04] Energy value shifts right by the digit-shift setting for display and communication.
// [R05] Digit shift 0 to 4: energy clamps at its maximum instead of wrapping.
// [R06] Digit shift 9999: energy over its maximum restarts from zero.
// [R07] Writing zero to the energy clear setting zeroes the energy accumulator.
// [R08] After clearing, energy clear setting reads back 9999 or 10, never zero.
// [R09] Power-on hours count every energised hour; monitor code 20 shows them.
// [R10] Running hours count only while operating, hold at stop; code 23 shows them.
// [R11] Each hour counter rolls to zero past 65535.
// [R12] Separate readable counts of hour counter rollovers, one per counter.
// [R13] Writing zero to runtime clear zeroes running hours; power-on hours never clear.
// [R14] Runtime clear reads back 9999 always; writing 9999 changes nothing.
// [R15] Running hours add only after a full continuous hour of operation.
// [R16] Decimal select 9999 leaves display; 0 truncates one or two decimals to integers.
// [R17] Decimal select 1 drops hundredths; unit-resolution values stay unchanged.
// [R18] Decimal select never alters hour counter or energy monitor digits.
// [R19] Frequency full scale, 0 to 400Hz, maps frequency linearly to analog full scale.
// [R20] Current analog output proportional to current over its full-scale reference.
// [R21] Voltage analog output smoothed, time constant default 0.01s, range 0 to 5s.
// [R22] Current analog output smoothed, time constant default 0.02s.
// [R23] Scaling and filter settings accepted any time, regardless of write protection.
// [R24] Output power integrated finely between hourly refreshes, no fraction lost.
package emon_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MS_NS = 1000000;
   localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOUR_S = 3600;
   localparam int HOUR_MS = HOUR_S * 1000;
   // 0.01kWh equals 10Wh, expressed in W*ms
   localparam logic [25:0] WMS_PER_STEP = 26'h2255100;
   // setting codes
   localparam logic [13:0] SET_CLEAR = 14'h0000;
   localparam logic [13:0] SET_KEEP = 14'h270f;
   localparam logic [13:0] SET_COMM10 = 14'h000a;
   localparam logic [13:0] SHIFT_LAST = 14'h0004;
   localparam logic [13:0] DEC_INT = 14'h0000;
   localparam logic [13:0] DEC_ONE = 14'h0001;
   // monitor selection codes
   localparam logic [7:0] MON_PON = 8'h14;
   localparam logic [7:0] MON_RUN = 8'h17;
   localparam logic [7:0] MON_ENERGY = 8'h19;
   localparam logic [7:0] MON_SAVED = 8'h33;
   // ranges
   localparam logic [15:0] HOURS_MAX = 16'hffff;
   localparam logic [39:0] ENERGY_MAX = 40'h000098967f;
   localparam logic [15:0] COMM_MAX_10 = 16'h270f;
   localparam logic [15:0] COMM_MAX_FULL = 16'hffff;
   localparam logic [23:0] VAL_9999 = 24'h00270f;
   localparam logic [23:0] VAL_99999 = 24'h01869f;
   localparam logic [23:0] VAL_999999 = 24'h0f423f;
   localparam logic [39:0] POW10 [0:4] = '{40'h1, 40'ha, 40'h64, 40'h3e8, 40'h2710};
   // analog outputs
   localparam logic [11:0] AOUT_FULL = 12'hfff;
   localparam logic [15:0] FREQ_FS_MAX = 16'h9c40;
   localparam logic [15:0] FREQ_FS_INIT = 16'h1770;
   localparam logic [15:0] VOUT_TC_MS = 16'h000a;
   localparam logic [15:0] COUT_TC_MS = 16'h0014;
   localparam logic [15:0] TC_MAX_MS = 16'h1388;
endpackage

// File: hw/emon_filt_if.sv
// filter link between the monitor core and its smoothing filters
`timescale 1ns/100ps
interface emon_filt_if;
   logic [11:0] target;
   logic [15:0] tc_ms;
   logic tick;
   logic [11:0] level;
   modport drv (output target, output tc_ms, output tick, input level);
   modport filt (input target, input tc_ms, input tick, output level);
endinterface

// File: hw/emon_lpf.sv
// first order smoothing filter stepped once per millisecond
`timescale 1ns/100ps
module emon_lpf
   import emon_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   emon_filt_if.filt f
);
   typedef struct packed {
      logic [27:0] acc;
   } emon_lpf_state_type;

   emon_lpf_state_type st_reg;
   emon_lpf_state_type st_next;
   logic [3:0] sh;
   logic [15:0] tc;
   logic signed [28:0] diff;

   // time constant to shift, roughly log2 of milliseconds
   always_comb begin
      tc = (f.tc_ms > TC_MAX_MS) ? TC_MAX_MS : f.tc_ms;
      sh = 4'h0;
      for (int i = 1; i < 13; i++) begin
         if (tc >= 16'(1 << i)) begin
            sh = 4'(i);
         end
      end
   end

   // state update
   always_comb begin
      st_next = st_reg;
      diff = $signed({1'b0, f.target, 16'h0000}) - $signed({1'b0, st_reg.acc});
      if (f.tick) begin
         if (sh == 4'h0) begin
            st_next.acc = {f.target, 16'h0000};
         end else begin
            st_next.acc = 28'($signed({1'b0, st_reg.acc}) + (diff >>> sh));
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign f.level = st_reg.acc[27:16];

   a_filt_pass: assert property (@(posedge clk_sys_i) disable iff (rst_i) // see [R21]
      f.tick && f.tc_ms == 16'h0000 |=> f.level == $past(f.target))
      else $error("filter with zero time constant did not pass target");
endmodule

// File: hw/emon_top.sv
// energy, power-on and running hour monitor with analog output scaling
`timescale 1ns/100ps
module emon_top
   import emon_pkg::*;
#(
   parameter int MS_CYCLES_P = MS_CYCLES,
   parameter int HOUR_MS_P = HOUR_MS
)
(
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic running_i,
   input wire logic [15:0] power_w_i,
   input wire logic [7:0] monitor_select_i,
   input wire logic [15:0] monitor_value_i,
   input wire logic [1:0] monitor_decimals_i,
   input wire logic [13:0] decimal_digit_select_i,
   input wire logic [13:0] energy_digit_shift_i,
   input wire logic energy_clear_wr_i,
   input wire logic [13:0] energy_clear_data_i,
   input wire logic runtime_clear_wr_i,
   input wire logic [13:0] runtime_clear_data_i,
   input wire logic [15:0] freq_i,
   input wire logic [15:0] current_i,
   input wire logic [15:0] frequency_full_scale_i,
   input wire logic [15:0] current_full_scale_i,
   input wire logic [15:0] voltage_out_filter_i,
   input wire logic [15:0] current_out_filter_i,
   output logic [13:0] energy_clear_setting_o,
   output logic [13:0] runtime_clear_setting_o,
   output logic [39:0] energy_total_o,
   output logic [15:0] energy_comm_o,
   output logic [23:0] panel_energy_o,
   output logic [1:0] panel_energy_dec_o,
   output logic [23:0] pu_energy_o,
   output logic [1:0] pu_energy_dec_o,
   output logic [23:0] display_value_o,
   output logic [1:0] display_dec_o,
   output logic [15:0] poweron_hours_o,
   output logic [15:0] runtime_hours_o,
   output logic [15:0] poweron_hours_wrap_count_o,
   output logic [15:0] runtime_hours_wrap_count_o,
   output logic [11:0] voltage_analog_output_o,
   output logic [11:0] current_analog_output_o
);
   localparam int MSW = $clog2(MS_CYCLES_P + 1);
   localparam int HMW = $clog2(HOUR_MS_P + 1);

   typedef struct packed {
      logic [MSW-1:0] ms_cnt;
      logic [HMW-1:0] hr_ms;
      logic [HMW-1:0] run_ms;
      logic [25:0] fine;
      logic [39:0] acc;
      logic [39:0] energy;
      logic [13:0] clr_mode;
      logic [15:0] pon_h;
      logic [15:0] pon_w;
      logic [15:0] run_h;
      logic [15:0] run_w;
      logic [15:0] comm;
      logic [23:0] panel_val;
      logic [1:0] panel_dec;
      logic [23:0] pu_val;
      logic [1:0] pu_dec;
      logic [23:0] mon_val;
      logic [1:0] mon_dec;
      logic [11:0] vtgt;
      logic [11:0] ctgt;
   } emon_state_type;

   emon_state_type st_reg;
   emon_state_type st_next;

   logic ms_tick;
   logic hour_tick;
   logic run_tick;
   logic clr_e;
   logic clr_r;
   logic wrap_mode;
   logic [2:0] shift_sel;
   logic [39:0] limit;
   logic [26:0] fine_sum;
   logic carry;
   logic [39:0] shifted;
   logic [15:0] freq_fs;
   logic [27:0] vprod;
   logic [27:0] cprod;
   logic [27:0] vq;
   logic [27:0] cq;

   emon_filt_if vf ();
   emon_filt_if cf ();

   ////////////////////////////////////////////////////////////////////////
   // time base and events

   // millisecond and hour enables
   assign ms_tick = st_reg.ms_cnt == MSW'(MS_CYCLES_P - 1);
   assign hour_tick = ms_tick && st_reg.hr_ms == HMW'(HOUR_MS_P - 1); // see [R09]
   // a full continuous hour of operation
   assign run_tick = ms_tick && running_i && st_reg.run_ms == HMW'(HOUR_MS_P - 1); // see [R15]
   assign clr_e = energy_clear_wr_i && energy_clear_data_i == SET_CLEAR; // see [R07]
   assign clr_r = runtime_clear_wr_i && runtime_clear_data_i == SET_CLEAR; // see [R13]

   ////////////////////////////////////////////////////////////////////////
   // energy range selection

   // shift and overflow mode from the digit-shift setting
   always_comb begin
      wrap_mode = energy_digit_shift_i == SET_KEEP; // see [R06]
      shift_sel = (energy_digit_shift_i <= SHIFT_LAST) ? energy_digit_shift_i[2:0] : 3'h0;
      limit = 40'(ENERGY_MAX * POW10[shift_sel] + POW10[shift_sel] - 40'h1);
      fine_sum = {1'b0, st_reg.fine} + {11'h000, power_w_i};
      carry = ms_tick && fine_sum >= {1'b0, WMS_PER_STEP}; // see [R24]
   end

   // right digit shift of the hourly total
   always_comb begin
      case (shift_sel)
         3'h1: shifted = st_reg.energy / 40'ha;
         3'h2: shifted = st_reg.energy / 40'h64;
         3'h3: shifted = st_reg.energy / 40'h3e8;
         3'h4: shifted = st_reg.energy / 40'h2710;
         default: shifted = st_reg.energy;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // analog output targets

   // linear scaling to full scale, saturated
   always_comb begin
      freq_fs = (frequency_full_scale_i > FREQ_FS_MAX) ? FREQ_FS_MAX : frequency_full_scale_i;
      vprod = 28'(freq_i) * 28'(AOUT_FULL);
      cprod = 28'(current_i) * 28'(AOUT_FULL);
      vq = (freq_fs == 16'h0000) ? {16'h0000, AOUT_FULL} : vprod / {12'h000, freq_fs};
      cq = (current_full_scale_i == 16'h0000) ? {16'h0000, AOUT_FULL}
         : cprod / {12'h000, current_full_scale_i};
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      st_next = st_reg;
      // millisecond prescaler and hour position
      st_next.ms_cnt = ms_tick ? '0 : MSW'(st_reg.ms_cnt + 1'b1);
      if (ms_tick) begin
         st_next.hr_ms = hour_tick ? '0 : HMW'(st_reg.hr_ms + 1'b1);
      end
      // continuous run time, lost on stop
      if (!running_i) begin
         st_next.run_ms = '0; // see [R15]
      end else if (ms_tick) begin
         st_next.run_ms = run_tick ? '0 : HMW'(st_reg.run_ms + 1'b1);
      end

      // fine power integration in W*ms
      if (ms_tick) begin
         st_next.fine = carry ? 26'(fine_sum - {1'b0, WMS_PER_STEP}) : fine_sum[25:0]; // see [R24]
      end
      // accumulator in 0.01kWh steps
      if (clr_e) begin
         st_next.acc = '0; // see [R07]
         st_next.fine = '0;
      end else if (carry) begin // see [R01]
         if (st_reg.acc >= limit) begin
            st_next.acc = wrap_mode ? 40'h0 : limit; // see [R05] [R06]
         end else begin
            st_next.acc = st_reg.acc + 40'h1;
         end
      end
      // hourly refresh of the shown total
      if (clr_e) begin
         st_next.energy = '0;
      end else if (hour_tick) begin
         st_next.energy = st_reg.acc; // see [R01]
      end
      // energy clear setting keeps the last 10 or 9999 code written
      if (energy_clear_wr_i && (energy_clear_data_i == SET_COMM10 || energy_clear_data_i == SET_KEEP)) begin
         st_next.clr_mode = energy_clear_data_i; // see [R08]
      end

      // power-on hours with rollover count
      if (hour_tick) begin // see [R09]
         st_next.pon_h = 16'(st_reg.pon_h + 16'h1); // see [R11]
         if (st_reg.pon_h == HOURS_MAX) begin
            st_next.pon_w = 16'(st_reg.pon_w + 16'h1); // see [R12]
         end
      end
      // running hours, held during stop
      if (clr_r) begin
         st_next.run_h = '0; // see [R13]
      end else if (run_tick) begin // see [R10]
         st_next.run_h = 16'(st_reg.run_h + 16'h1); // see [R11]
         if (st_reg.run_h == HOURS_MAX) begin
            st_next.run_w = 16'(st_reg.run_w + 16'h1); // see [R12]
         end
      end

      // communication value in 1kWh units
      st_next.comm = (shifted / 40'h64 > {24'h0, COMM_MAX_FULL}) ? COMM_MAX_FULL
         : 16'(shifted / 40'h64); // see [R04]
      if (st_reg.clr_mode == SET_COMM10 && st_next.comm > COMM_MAX_10) begin
         st_next.comm = COMM_MAX_10;
      end

      // four-digit panel format
      if (shifted[23:0] <= VAL_9999 && shifted[39:24] == 16'h0) begin // see [R02]
         st_next.panel_val = shifted[23:0];
         st_next.panel_dec = 2'h2;
      end else if (shifted <= {16'h0, VAL_99999}) begin
         st_next.panel_val = 24'(shifted / 40'ha);
         st_next.panel_dec = 2'h1;
      end else begin
         st_next.panel_val = (shifted / 40'h64 > {16'h0, VAL_9999}) ? VAL_9999 : 24'(shifted / 40'h64);
         st_next.panel_dec = 2'h0;
      end
      // five-digit unit format
      if (shifted <= {16'h0, VAL_99999}) begin // see [R03]
         st_next.pu_val = shifted[23:0];
         st_next.pu_dec = 2'h2;
      end else if (shifted <= {16'h0, VAL_999999}) begin
         st_next.pu_val = 24'(shifted / 40'ha);
         st_next.pu_dec = 2'h1;
      end else begin
         st_next.pu_val = 24'(shifted / 40'h64);
         st_next.pu_dec = 2'h0;
      end

      // selected monitor with decimal select
      case (monitor_select_i)
         MON_PON: begin // see [R18]
            st_next.mon_val = {8'h00, st_reg.pon_h};
            st_next.mon_dec = 2'h0;
         end
         MON_RUN: begin
            st_next.mon_val = {8'h00, st_reg.run_h};
            st_next.mon_dec = 2'h0;
         end
         MON_ENERGY, MON_SAVED: begin
            st_next.mon_val = st_next.panel_val;
            st_next.mon_dec = st_next.panel_dec;
         end
         default: begin
            st_next.mon_val = {8'h00, monitor_value_i};
            st_next.mon_dec = monitor_decimals_i;
            if (decimal_digit_select_i == DEC_INT && monitor_decimals_i != 2'h0) begin // see [R16]
               st_next.mon_val = (monitor_decimals_i == 2'h1) ? 24'(monitor_value_i / 16'ha)
                  : 24'(monitor_value_i / 16'h64);
               st_next.mon_dec = 2'h0;
            end else if (decimal_digit_select_i == DEC_ONE && monitor_decimals_i == 2'h2) begin
               st_next.mon_val = 24'(monitor_value_i / 16'ha); // see [R17]
               st_next.mon_dec = 2'h1;
            end
         end
      endcase

      // analog targets, settings taken live at any time
      st_next.vtgt = (vq > {16'h0, AOUT_FULL}) ? AOUT_FULL : vq[11:0]; // see [R19] [R23]
      st_next.ctgt = (cq > {16'h0, AOUT_FULL}) ? AOUT_FULL : cq[11:0]; // see [R20]
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_reg <= '0;
         st_reg.clr_mode <= SET_KEEP;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // smoothing filters

   // voltage output filter
   assign vf.target = st_reg.vtgt;
   assign vf.tc_ms = voltage_out_filter_i; // see [R21]
   assign vf.tick = ms_tick;
   // current output filter
   assign cf.target = st_reg.ctgt;
   assign cf.tc_ms = current_out_filter_i; // see [R22]
   assign cf.tick = ms_tick;

   emon_lpf u_vfilt (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .f(vf.filt)
   );

   emon_lpf u_cfilt (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .f(cf.filt)
   );

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign energy_clear_setting_o = st_reg.clr_mode;
   assign runtime_clear_setting_o = SET_KEEP; // see [R14]
   assign energy_total_o = st_reg.energy;
   assign energy_comm_o = st_reg.comm;
   assign panel_energy_o = st_reg.panel_val;
   assign panel_energy_dec_o = st_reg.panel_dec;
   assign pu_energy_o = st_reg.pu_val;
   assign pu_energy_dec_o = st_reg.pu_dec;
   assign display_value_o = st_reg.mon_val;
   assign display_dec_o = st_reg.mon_dec;
   assign poweron_hours_o = st_reg.pon_h;
   assign runtime_hours_o = st_reg.run_h;
   assign poweron_hours_wrap_count_o = st_reg.pon_w;
   assign runtime_hours_wrap_count_o = st_reg.run_w;
   assign voltage_analog_output_o = vf.level;
   assign current_analog_output_o = cf.level;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   sequence s_hour_edge;
      hour_tick && !clr_e;
   endsequence

   sequence s_top_step;
      carry && st_reg.acc >= limit && !clr_e;
   endsequence

   a_hour_refresh: assert property (s_hour_edge |=> st_reg.energy == $past(st_reg.acc)) // see [R01]
      else $error("hourly energy refresh missed");
   a_energy_hold: assert property (!hour_tick && !clr_e |=> $stable(st_reg.energy)) // see [R01]
      else $error("energy total changed between hours");
   a_energy_clear: assert property (clr_e |=> st_reg.acc == 40'h0 && energy_total_o == 40'h0) // see [R07]
      else $error("energy clear did not zero the total");
   a_clear_readback: assert property (energy_clear_wr_i ##1 1'b1 |-> energy_clear_setting_o != SET_CLEAR) // see [R08]
      else $error("energy clear setting reads zero");
   a_energy_clamp: assert property ((s_top_step and !wrap_mode) |=> st_reg.acc == $past(limit)) // see [R05]
      else $error("energy did not clamp at maximum");
   a_energy_wrap: assert property ((s_top_step and wrap_mode) |=> st_reg.acc == 40'h0) // see [R06]
      else $error("energy did not restart from zero");
   a_pon_wrap: assert property (hour_tick && st_reg.pon_h == HOURS_MAX |=> // see [R11]
      poweron_hours_o == 16'h0 && poweron_hours_wrap_count_o == 16'($past(st_reg.pon_w) + 16'h1))
      else $error("power-on hour rollover wrong");
   a_run_stop: assert property (!running_i && !clr_r |=> $stable(runtime_hours_o)) // see [R10]
      else $error("running hours moved during stop");
   a_run_keep: assert property (runtime_clear_wr_i && runtime_clear_data_i == SET_KEEP && !run_tick // see [R14]
      |=> $stable(runtime_hours_o) && runtime_clear_setting_o == SET_KEEP)
      else $error("runtime keep write changed hours");
   a_run_full_hour: assert property (!run_tick && !clr_r |=> $stable(runtime_hours_o)) // see [R15]
      else $error("running hours added without a full hour");
   a_pon_count: assert property (hour_tick |=> poweron_hours_o == 16'($past(st_reg.pon_h) + 16'h1)) // see [R09]
      else $error("power-on hours did not advance");
endmodule

// File: testbench/emon_host_model.sv
// host side model issuing one-cycle setting writes
`timescale 1ns/100ps
module emon_host_model (
   input wire logic clk_sys_i,
   output logic energy_clear_wr_o,
   output logic [13:0] energy_clear_data_o,
   output logic runtime_clear_wr_o,
   output logic [13:0] runtime_clear_data_o
);
   initial begin
      energy_clear_wr_o = 1'b0;
      energy_clear_data_o = 14'h1555;
      runtime_clear_wr_o = 1'b0;
      runtime_clear_data_o = 14'h2aaa;
   end
   ////////////////////////////////////////////////////////////////
   // strobe and data held across one rising edge, data scrambled after
   task automatic write_energy(input logic [13:0] d);
      @(negedge clk_sys_i);
      energy_clear_wr_o = 1'b1;
      energy_clear_data_o = d;
      @(negedge clk_sys_i);
      energy_clear_wr_o = 1'b0;
      energy_clear_data_o = ~d;
   endtask
   task automatic write_runtime(input logic [13:0] d);
      @(negedge clk_sys_i);
      runtime_clear_wr_o = 1'b1;
      runtime_clear_data_o = d;
      @(negedge clk_sys_i);
      runtime_clear_wr_o = 1'b0;
      runtime_clear_data_o = ~d;
   endtask
endmodule

// File: testbench/emon_top_test.sv
// self-checking bench for the energy and runtime monitor
`timescale 1ns/100ps
module emon_top_test;
   import emon_pkg::*;
   localparam int MSC = 4;
   localparam int HMS = 5;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic running_i = 1'b1;
   logic [15:0] power_w_i = 16'hffff;
   logic [7:0] msel = MON_ENERGY;
   logic [15:0] mval = 16'h0000;
   logic [1:0] mdec = 2'h0;
   logic [13:0] dsel = DEC_INT;
   logic [13:0] shift = 14'h0000;
   logic [15:0] freq = 16'h0bb8;
   logic [15:0] ffs = FREQ_FS_INIT;
   logic [15:0] cur = 16'h07d0;
   logic [15:0] vtc = VOUT_TC_MS;
   logic [15:0] ctc = COUT_TC_MS;
   logic ewr, rwr;
   logic [13:0] ed, rd, eset, rset;
   logic [39:0] etot;
   logic [15:0] ecomm, pon, run, ponw, runw;
   logic [23:0] pan, pu, disp;
   logic [1:0] pand, pud, dispd;
   logic [11:0] vout, cout;
   int err_count = 0;
   int n_compared = 0;
   int cycles = 0;
   always #5 clk_sys_i = ~clk_sys_i;
   emon_host_model i_emon_host_model (.clk_sys_i(clk_sys_i), .energy_clear_wr_o(ewr),
      .energy_clear_data_o(ed), .runtime_clear_wr_o(rwr), .runtime_clear_data_o(rd));
   emon_top #(.MS_CYCLES_P(MSC), .HOUR_MS_P(HMS)) i_emon_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .running_i(running_i), .power_w_i(power_w_i), .monitor_select_i(msel), .monitor_value_i(mval),
      .monitor_decimals_i(mdec), .decimal_digit_select_i(dsel), .energy_digit_shift_i(shift),
      .energy_clear_wr_i(ewr), .energy_clear_data_i(ed), .runtime_clear_wr_i(rwr),
      .runtime_clear_data_i(rd), .freq_i(freq), .current_i(cur), .frequency_full_scale_i(ffs),
      .current_full_scale_i(16'h03e8), .voltage_out_filter_i(vtc), .current_out_filter_i(ctc),
      .energy_clear_setting_o(eset), .runtime_clear_setting_o(rset), .energy_total_o(etot),
      .energy_comm_o(ecomm), .panel_energy_o(pan), .panel_energy_dec_o(pand), .pu_energy_o(pu),
      .pu_energy_dec_o(pud), .display_value_o(disp), .display_dec_o(dispd), .poweron_hours_o(pon),
      .runtime_hours_o(run), .poweron_hours_wrap_count_o(ponw), .runtime_hours_wrap_count_o(runw),
      .voltage_analog_output_o(vout), .current_analog_output_o(cout));
   ////////////////////////////////////////////////////////////////
   // verdict and shared helpers
   task automatic finish_test();
      if (err_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input bit ok, input string m);
      n_compared++;
      if (!ok) begin
         err_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   // hang guard
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles >= 40000) begin
         err_count++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_energy();
      longint e;
      e = (longint'(1100) * HMS * 65535) / 36000000;
      while (pon !== 16'd1100) cyc(1);
      cyc(8);
      chk(etot === 40'(e), "energy total");
      chk(pan === 24'(e) && pand === 2'h2, "panel form");
      chk(pu === 24'(e) && pud === 2'h2, "unit form");
      chk(ecomm === 16'h0000, "comm value");
      chk(disp === 24'(e) && dispd === 2'h2, "energy display");
      shift = 14'h0001;
      cyc(3);
      chk(pan === 24'(e / 10), "shifted panel");
      shift = 14'h0000;
      i_emon_host_model.write_energy(SET_CLEAR);
      chk(etot === 40'h0 && eset === SET_KEEP, "energy clear");
      i_emon_host_model.write_energy(SET_COMM10);
      chk(eset === SET_COMM10, "readback ten");
   endtask
   task automatic t_decimal();
      logic [15:0] v [6] = '{16'd1234, 16'd1234, 16'd1234, 16'd99, 16'd57, 16'd456};
      logic [1:0] d [6] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1};
      logic [13:0] s [6] = '{DEC_INT, DEC_ONE, SET_KEEP, DEC_INT, DEC_ONE, DEC_INT};
      logic [23:0] ev [6] = '{24'd12, 24'd123, 24'd1234, 24'd0, 24'd57, 24'd45};
      logic [1:0] ed2 [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0};
      msel = 8'h00;
      for (int i = 0; i < 6; i++) begin
         mval = v[i];
         mdec = d[i];
         dsel = s[i];
         cyc(3);
         chk(disp === ev[i] && dispd === ed2[i], "decimal select");
      end
      msel = MON_RUN;
   endtask
   task automatic t_hours();
      logic [15:0] p0, r0;
      p0 = pon;
      r0 = run;
      chk(r0 === p0 && rset === SET_KEEP, "hours equal");
      running_i = 1'b0;
      while (pon !== p0 + 16'd2) cyc(1);
      chk(run === r0 && ponw === 16'h0 && runw === 16'h0, "stop holds");
      chk(disp === {8'h00, run} && dispd === 2'h0, "run display");
      running_i = 1'b1;
      cyc(12);
      chk(run === r0, "partial hour");
      cyc(16);
      chk(run === r0 + 16'd1, "full hour");
      i_emon_host_model.write_runtime(SET_KEEP);
      chk(run === r0 + 16'd1, "keep write");
      p0 = pon;
      i_emon_host_model.write_runtime(SET_CLEAR);
      chk(run === 16'h0 && pon === p0 && rset === SET_KEEP, "runtime clear");
   endtask
   task automatic t_analog();
      cyc(8);
      chk(cout > 12'h000 && cout < 12'hfff, "current smoothing");
      cyc(1200);
      chk(vout >= 12'd2032 && vout <= 12'd2047, "voltage scale");
      chk(cout >= 12'hfe0, "current scale");
      // full scale moved onto the present frequency, filter bypassed, during operation
      ffs = 16'h0bb8;
      vtc = 16'h0000;
      cyc(8);
      chk(vout === 12'hfff, "live full scale");
   endtask
   initial begin
      cyc(3);
      rst_i = 1'b0;
      chk(eset === SET_KEEP && pon === 16'h0 && vout === 12'h0, "reset values");
      t_energy();
      t_decimal();
      t_hours();
      cur = 16'h0000;
      cyc(400);
      cur = 16'h07d0;
      t_analog();
      finish_test();
   end
endmodule
